// ---- core/clk_irq_cfg.sv ----
// Clock-loss supervision, boost UV routing and driver interrupt config.
`timescale 1ns/1ps
// Functional notes
// - Boost UV flag needs drive-off; core/host irqs need enables and routes.
// - Boost irq enable admits boost UV as a local driver interrupt.
// - Return requests go to all cores, never for clock-loss causes.
// - Select 0: return request when drivers are re-enabled.
// - Select 1: return request when driver status is cleared.
// - Boost drive-off enabled: boost undervoltage disables all drivers.
// - Boost divider select: divide by 32 at 0, by 4 at 1.
// - External supply bit 0 keeps regulator on, 1 turns it off.
// - During bootstrap init use inverted latched strap instead.
// - Strap caught at power-on or pin reset release, not SPI reset.
// - PLL factor 12 when cleared, 24 when set.
// - Spread applied when spread-disable is 0, none when 1.
// - PLL factor change applied on a clock monitor cycle tick.
// - PLL register resets on power-on, pin and SPI reset.
// - Reference-missing bit latches whenever reference is absent.
// - Return request bit cleared once PLL back on external reference.
// - Return request without clock loss clears at once, no action.
// - Reference-missing clears only after a completed return.
// - Host clock irq held until supervision register read.
// - Six per-core enables gate the clock-missing interrupt.
// - Clock-fail drive-off withholds drivers while clock missing.
// - Clock irq fires on each switch to internal and each return try.
// - Host clock irq retriggered throughout the clock-missing condition; core irqs only at its onset, on switches to internal and on return tries.
module clk_irq_cfg
    import clk_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        powerOnReset_n,
    input  wire logic        externalReset_n,
    input  wire logic        debugPinIn,
    input  wire logic        boostUvDetect,
    input  wire logic        refClockAbsent,
    input  wire logic        sysClockMissing,
    input  wire logic        switchedToInternal,
    input  wire logic        switchedToExternal,
    input  wire logic        clockMonitorTick,
    input  wire logic        bootstrapInit,
    input  wire logic        driversReenabled,
    input  wire logic        driverStatusCleared,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             driversDisable,
    output logic             hostIrq,
    output logic [5:0]       coreIrq,
    output logic [5:0]       coreIret,
    output logic             returnToExtRef,
    output logic             pllFactorHigh,
    output logic             pllSpreadOn,
    output logic             boostDivBy4,
    output logic             vccpExtEnable
);

    clk_state_s st_ff;
    clk_state_s nxt_st;
    logic       drvOff_ff;
    logic       hostIrq_ff;
    logic [5:0] coreIrq_ff;
    logic [5:0] coreIret_ff;
    logic       retOut_ff;
    logic       pllHi_ff;
    logic       spread_ff;
    logic       div4_ff;
    logic       ext_ff;
    logic       anyRst;
    logic       spiOnly;
    logic       addrOk;
    logic       boostSrc;
    logic       drvOffNow;
    logic       bkpRead;
    logic       retRise;

    // Word decode from a byte address; printed offsets are word indices.
    function automatic logic [15:0] read_word(input clk_state_s s,
                                              input logic [8:0] idx);
        logic [15:0] r;
        r = 16'h0000;
        unique case (idx)
            IDX_DRV_CFG1: r = s.cfg1 & 16'h1fff;
            IDX_DRV_CFG2: r = s.cfg2 & 16'h8007;
            IDX_PLL_CFG:  r = s.pll & 16'h0003;
            IDX_BKP_CLK:  r = s.bkp & 16'h41ff;
            IDX_STATUS:   r = {14'h0000, s.hostClkIrq, s.boostUv};
            default:      r = 16'h0000;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset sources: pin resets clear everything, SPI reset (reset) spares
    // the strap.

    assign anyRst  = reset || !powerOnReset_n || !externalReset_n;
    assign spiOnly = reset && powerOnReset_n && externalReset_n;
    assign addrOk  = (haddr[1:0] == 2'b00) && (haddr[31:11] == 21'h0_0000);
    assign bkpRead = (st_ff.hState == H_RD) && (st_ff.hIdx == IDX_BKP_CLK);
    assign retRise = st_ff.bkp[BB_RETURN] && !st_ff.retPrev;

    // Boost UV as a driver interrupt source needs both enables.
    assign boostSrc = st_ff.cfg1[B1_BOOST_IE] && st_ff.cfg2[B2_BOOST_DO]
                      && boostUvDetect;
    assign drvOffNow = (st_ff.cfg2[B2_BOOST_DO] && boostUvDetect)
        || (st_ff.bkp[BB_CLK_DO] && sysClockMissing);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, registers, strap and event flags.

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rstPrev    = anyRst;
        nxt_st.missPrev   = sysClockMissing;
        nxt_st.drvOffPrev = drvOffNow;
        nxt_st.retPrev    = st_ff.bkp[BB_RETURN];
        // Strap taken at the release of a pin reset only.
        if (st_ff.rstPrev && !anyRst && !st_ff.strapDone) begin
            nxt_st.strap     = debugPinIn;
            nxt_st.strapDone = 1'b1;
        end
        // Data phase of a prior write lands one cycle after address phase.
        nxt_st.hState = H_IDLE;
        if (st_ff.hState == H_WR) begin
            unique case (st_ff.hIdx)
                IDX_DRV_CFG1: nxt_st.cfg1 = hwdata[15:0] & 16'h1fff;
                IDX_DRV_CFG2: nxt_st.cfg2 = hwdata[15:0] & 16'h8007;
                IDX_PLL_CFG:  nxt_st.pll  = hwdata[15:0] & 16'h0003;
                IDX_BKP_CLK: begin
                    nxt_st.bkp[15:1] = hwdata[15:1] & 15'h20ff;
                end
                default: ;
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            nxt_st.hState = hwrite ? H_WR : H_RD;
            nxt_st.hIdx   = addrOk ? haddr[10:2] : 9'h000;
            nxt_st.hRdata = addrOk ? {16'h0000,
                                      read_word(st_ff, haddr[10:2])}
                                   : 32'h0000_0000;
        end
        // Boost UV flag sets only with drive-off enabled; cleared by a
        // status read, but a new event in that cycle wins.
        if (st_ff.hState == H_RD && st_ff.hIdx == IDX_STATUS) begin
            nxt_st.boostUv = 1'b0;
        end
        if (st_ff.cfg2[B2_BOOST_DO] && boostUvDetect) begin
            nxt_st.boostUv = 1'b1;
        end
        // Host clock irq cleared by reading supervision register; set wins.
        if (bkpRead) begin
            nxt_st.hostClkIrq = 1'b0;
        end
        if (st_ff.bkp[BB_HOST_IE] && sysClockMissing) begin
            nxt_st.hostClkIrq = 1'b1;
        end
        // Return request: immediate clear without a loss, else on switch.
        if (retRise && !st_ff.bkp[BB_REF_MISS]) begin
            nxt_st.bkp[BB_RETURN] = 1'b0;
        end
        if (st_ff.bkp[BB_RETURN] && st_ff.bkp[BB_REF_MISS]
            && switchedToExternal) begin
            nxt_st.bkp[BB_RETURN]   = 1'b0;
            nxt_st.bkp[BB_REF_MISS] = 1'b0;
        end
        if (refClockAbsent) begin
            nxt_st.bkp[BB_REF_MISS] = 1'b1;
        end
        if (anyRst) begin
            nxt_st.cfg1       = RST_DRV_CFG1;
            nxt_st.cfg2       = RST_DRV_CFG2;
            nxt_st.pll        = RST_PLL_CFG;
            nxt_st.bkp        = RST_BKP_CLK;
            nxt_st.boostUv    = 1'b0;
            nxt_st.hostClkIrq = 1'b0;
            nxt_st.hState     = H_IDLE;
            nxt_st.hIdx       = 9'h000;
            nxt_st.hRdata     = 32'h0000_0000;
            if (!spiOnly) begin
                nxt_st.strapDone = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register. Reset values come from the next-state logic, so the
    // reset edge detector sees the release and the strap is caught; only a
    // pin reset re-arms it, so an SPI reset keeps the caught level.

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops. Everything runs on one clock here; the backup
    // oscillator is expected to feed clk while the system clock is lost.

    always_ff @(posedge clk) begin
        if (anyRst) begin
            drvOff_ff   <= 1'b0;
            hostIrq_ff  <= 1'b0;
            coreIrq_ff  <= 6'h00;
            coreIret_ff <= 6'h00;
            retOut_ff   <= 1'b0;
            pllHi_ff    <= RST_PLL_CFG[BP_FACTOR];
            spread_ff   <= 1'b1;
            div4_ff     <= 1'b0;
            ext_ff      <= 1'b0;
        end else begin
            drvOff_ff <= drvOffNow;
            // Host pin: boost source with route, or latched clock irq.
            hostIrq_ff <= (boostSrc && st_ff.cfg1[B1_HOST_RT])
                          || st_ff.hostClkIrq;
            // Core irqs: boost route, or clock-missing onsets, switches to internal and retries.
            // A switch-back attempt fires even once the clock is back, as
            // long as the loss is still latched.
            coreIrq_ff <= ({6{boostSrc}} & st_ff.cfg1[6:1])
                | ({6{(sysClockMissing && (switchedToInternal
                   || !st_ff.missPrev))
                   || (retRise && st_ff.bkp[BB_REF_MISS])}}
                   & st_ff.bkp[8:3]);
            // Return requests to all cores; never while clock is missing.
            coreIret_ff <= {6{!sysClockMissing &&
                ((!st_ff.cfg1[B1_IRET_SEL] && driversReenabled)
                 || (st_ff.cfg1[B1_IRET_SEL]
                     && driverStatusCleared))}};
            // A request with no clock loss is dropped without reaching
            // the clock manager.
            retOut_ff <= st_ff.bkp[BB_RETURN]
                         && st_ff.bkp[BB_REF_MISS];
            // PLL factor moves only on the monitor tick.
            if (clockMonitorTick) begin
                pllHi_ff <= st_ff.pll[BP_FACTOR];
            end
            spread_ff <= !st_ff.pll[BP_SPREAD_D];
            div4_ff   <= st_ff.cfg2[B2_BOOST_DV];
            ext_ff    <= bootstrapInit ? !st_ff.strap
                                       : st_ff.cfg2[B2_EXT_SUP];
        end
    end

    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = st_ff.hRdata;
    assign driversDisable = drvOff_ff;
    assign hostIrq        = hostIrq_ff;
    assign coreIrq        = coreIrq_ff;
    assign coreIret       = coreIret_ff;
    assign returnToExtRef = retOut_ff;
    assign pllFactorHigh  = pllHi_ff;
    assign pllSpreadOn    = spread_ff;
    assign boostDivBy4    = div4_ff;
    assign vccpExtEnable  = ext_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    property p_boost_flag;
        @(posedge clk) disable iff (anyRst)
        (!st_ff.cfg2[B2_BOOST_DO]) |=> !$rose(st_ff.boostUv);
    endproperty
    a_boost_flag: assert property (p_boost_flag)
        else $error("Boost flag set without drive-off enable.");

    property p_boost_core;
        @(posedge clk) disable iff (anyRst)
        (boostSrc && st_ff.cfg1[B1_CORE_RT]) |=> coreIrq[0];
    endproperty
    a_boost_core: assert property (p_boost_core)
        else $error("Boost UV not routed to core 0.");

    property p_no_iret_loss;
        @(posedge clk) disable iff (anyRst)
        sysClockMissing |=> (coreIret == 6'h00);
    endproperty
    a_no_iret_loss: assert property (p_no_iret_loss)
        else $error("Return request during clock loss.");

    property p_iret_sel0;
        @(posedge clk) disable iff (anyRst)
        (!st_ff.cfg1[B1_IRET_SEL] && driversReenabled && !sysClockMissing)
            |=> (coreIret == 6'h3f);
    endproperty
    a_iret_sel0: assert property (p_iret_sel0)
        else $error("Missing return request on re-enable.");

    property p_drv_off;
        @(posedge clk) disable iff (anyRst)
        (st_ff.cfg2[B2_BOOST_DO] && boostUvDetect) |=> driversDisable;
    endproperty
    a_drv_off: assert property (p_drv_off)
        else $error("Drivers not disabled on boost UV.");

    property p_clk_off;
        @(posedge clk) disable iff (anyRst)
        (st_ff.bkp[BB_CLK_DO] && sysClockMissing) |=> driversDisable;
    endproperty
    a_clk_off: assert property (p_clk_off)
        else $error("Drivers not disabled on clock loss.");

    property p_pll_tick;
        @(posedge clk) disable iff (anyRst)
        !clockMonitorTick |=> $stable(pllFactorHigh);
    endproperty
    a_pll_tick: assert property (p_pll_tick)
        else $error("PLL factor moved off the monitor tick.");

    property p_ref_latch;
        @(posedge clk) disable iff (anyRst)
        refClockAbsent |=> st_ff.bkp[BB_REF_MISS];
    endproperty
    a_ref_latch: assert property (p_ref_latch)
        else $error("Reference-missing bit did not latch.");

    property p_host_hold;
        @(posedge clk) disable iff (anyRst)
        (st_ff.hostClkIrq && !bkpRead) |=> st_ff.hostClkIrq ##1 hostIrq;
    endproperty
    a_host_hold: assert property (p_host_hold)
        else $error("Host clock irq dropped before read.");

    property p_iret_sel1;
        @(posedge clk) disable iff (anyRst)
        (st_ff.cfg1[B1_IRET_SEL] && driverStatusCleared && !sysClockMissing)
            |=> (coreIret == 6'h3f);
    endproperty
    a_iret_sel1: assert property (p_iret_sel1)
        else $error("Missing return request on status clear.");

    property p_ret_drop;
        @(posedge clk) disable iff (anyRst)
        (retRise && !st_ff.bkp[BB_REF_MISS]) |=> !st_ff.bkp[BB_RETURN];
    endproperty
    a_ret_drop: assert property (p_ret_drop)
        else $error("Return request kept without clock loss.");

    property p_ret_done;
        @(posedge clk) disable iff (anyRst)
        (st_ff.bkp[BB_RETURN] && st_ff.bkp[BB_REF_MISS] && switchedToExternal)
            |=> !st_ff.bkp[BB_RETURN];
    endproperty
    a_ret_done: assert property (p_ret_done)
        else $error("Return request not cleared after switch back.");

    property p_miss_hold;
        @(posedge clk) disable iff (anyRst)
        (st_ff.bkp[BB_REF_MISS]
            && !(st_ff.bkp[BB_RETURN] && switchedToExternal))
            |=> st_ff.bkp[BB_REF_MISS];
    endproperty
    a_miss_hold: assert property (p_miss_hold)
        else $error("Reference-missing cleared without a return.");

    property p_core_gate;
        @(posedge clk) disable iff (anyRst)
        (st_ff.cfg1[6:1] == 6'h00 && st_ff.bkp[8:3] == 6'h00)
            |=> (coreIrq == 6'h00);
    endproperty
    a_core_gate: assert property (p_core_gate)
        else $error("Core interrupt without a route enable.");

    property p_host_route;
        @(posedge clk) disable iff (anyRst)
        (!st_ff.cfg1[B1_HOST_RT] && !st_ff.hostClkIrq) |=> !hostIrq;
    endproperty
    a_host_route: assert property (p_host_route)
        else $error("Host pin raised without a host route.");

    c_boost: cover property (@(posedge clk) boostSrc ##1 hostIrq);
    c_loss:  cover property (@(posedge clk) $rose(st_ff.bkp[BB_REF_MISS]));
    c_ret:   cover property (@(posedge clk) $fell(st_ff.bkp[BB_RETURN]));
    c_iret:  cover property (@(posedge clk) coreIret == 6'h3f);
    c_off:   cover property (@(posedge clk) $rose(driversDisable));

endmodule

// ---- core/clk_pkg.sv ----
// Package for the clock-loss and driver interrupt configuration block.
package clk_pkg;

    // Register word indices, printed offsets not multiples of four.
    localparam logic [8:0] IDX_DRV_CFG1 = 9'h1a5;
    localparam logic [8:0] IDX_DRV_CFG2 = 9'h1a6;
    localparam logic [8:0] IDX_PLL_CFG  = 9'h1a7;
    localparam logic [8:0] IDX_BKP_CLK  = 9'h1a8;
    localparam logic [8:0] IDX_STATUS   = 9'h1b0;

    // Reset values.
    localparam logic [15:0] RST_DRV_CFG1 = 16'h0000;
    localparam logic [15:0] RST_DRV_CFG2 = 16'h8000;
    localparam logic [15:0] RST_PLL_CFG  = 16'h0001;
    localparam logic [15:0] RST_BKP_CLK  = 16'h0000;

    // Field positions in the first driver configuration word.
    localparam int B1_HOST_RT  = 0;
    localparam int B1_CORE_RT  = 1;
    localparam int B1_IRET_SEL = 7;
    localparam int B1_BOOST_IE = 10;
    // Second driver configuration word.
    localparam int B2_BOOST_DO = 0;
    localparam int B2_BOOST_DV = 1;
    localparam int B2_EXT_SUP  = 15;
    // PLL word.
    localparam int BP_FACTOR   = 0;
    localparam int BP_SPREAD_D = 1;
    // Backup clock supervision word.
    localparam int BB_REF_MISS = 0;
    localparam int BB_RETURN   = 1;
    localparam int BB_HOST_IE  = 2;
    localparam int BB_CORE_IE  = 3;
    localparam int BB_CLK_DO   = 14;

    // PLL multiplication factors and boost divider ratios.
    localparam logic [4:0] PLL_MULT_LO  = 5'd12;
    localparam logic [4:0] PLL_MULT_HI  = 5'd24;
    localparam logic [5:0] BOOST_DIV_LO = 6'd32;
    localparam logic [5:0] BOOST_DIV_HI = 6'd4;

    // Register and sideband state carried as one packed struct.
    typedef struct packed {
        logic [15:0] cfg1;
        logic [15:0] cfg2;
        logic [15:0] pll;
        logic [15:0] bkp;
        logic        strap;
        logic        strapDone;
        logic        rstPrev;
        logic        retPrev;
        logic        missPrev;
        logic        drvOffPrev;
        logic        boostUv;
        logic        hostClkIrq;
        logic [2:0]  hState;
        logic        hWrite;
        logic [8:0]  hIdx;
        logic [31:0] hRdata;
    } clk_state_s;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_WR   = 3'b010,
        H_RD   = 3'b100
    } clk_hstate_e;

endpackage

// ---- test/clk_far_model.sv ----
// Behavioural clock manager facing the block's clock-loss inputs.
`timescale 1ns/1ps
module clk_far_model
    import clk_pkg::*;
#(
    parameter int TICK_PERIOD  = 8,
    parameter int SWITCH_DELAY = 4
)
(
    input  wire logic clk,
    input  wire logic loseClock,
    input  wire logic returnToExtRef,
    output logic      refClockAbsent,
    output logic      sysClockMissing,
    output logic      switchedToInternal,
    output logic      switchedToExternal,
    output logic      clockMonitorTick
);
    int   tickCnt = 0;
    int   swCnt   = 0;
    logic loseDly = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // A lost reference hands over to the backup source at once, so the
    // change-over pulse comes in the same cycle as the loss flags.
    always @(posedge clk) begin
        loseDly            <= loseClock;
        refClockAbsent     <= loseClock;
        sysClockMissing    <= loseClock;
        switchedToInternal <= loseClock & ~loseDly;
        tickCnt            <= (tickCnt + 1) % TICK_PERIOD;
        clockMonitorTick   <= (tickCnt == TICK_PERIOD - 1);
        // Switch back only while asked and with a valid reference.
        if (returnToExtRef && !loseClock) begin
            swCnt <= swCnt + 1;
        end else begin
            swCnt <= 0;
        end
        switchedToExternal <= (swCnt == SWITCH_DELAY);
    end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the clock-loss and driver interrupt block.
`timescale 1ns/1ps
module testbench
    import clk_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset, powerOnReset_n, externalReset_n, debugPinIn;
    logic        boostUvDetect, bootstrapInit, loseClock, hsel, hwrite;
    logic        driversReenabled, driverStatusCleared;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, rd;
    wire         hreadyout, hresp, driversDisable, hostIrq, returnToExtRef;
    wire         pllFactorHigh, pllSpreadOn, boostDivBy4, vccpExtEnable;
    wire         refClockAbsent, sysClockMissing, clockMonitorTick;
    wire         switchedToInternal, switchedToExternal;
    wire [31:0]  hrdata;
    wire [5:0]   coreIrq, coreIret;
    logic [5:0]  seenCore, seenIret;
    logic        seenHost, seenOff, seenRet;
    int          miscompares = 0;
    int          nCompared   = 0;

    // The one slave's ready closes the loop back onto its own input.
    clk_irq_cfg dut (.clk, .reset, .powerOnReset_n, .externalReset_n,
        .debugPinIn, .boostUvDetect, .refClockAbsent, .sysClockMissing,
        .switchedToInternal, .switchedToExternal, .clockMonitorTick,
        .bootstrapInit, .driversReenabled, .driverStatusCleared, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .driversDisable, .hostIrq, .coreIrq,
        .coreIret, .returnToExtRef, .pllFactorHigh, .pllSpreadOn,
        .boostDivBy4, .vccpExtEnable);
    clk_far_model #(.TICK_PERIOD(8), .SWITCH_DELAY(4)) farSide (.clk,
        .loseClock, .returnToExtRef, .refClockAbsent, .sysClockMissing,
        .switchedToInternal, .switchedToExternal, .clockMonitorTick);

    // A 5 ns period clock.
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    // Compare and count; an unknown never passes.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One single-word transfer; read data is taken at the data edge.
    task automatic bus(input logic wr, input logic [8:0] idx,
                       input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {21'h0, idx, 2'b00};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // Collect what the outputs showed over n cycles, pulses included.
    task automatic watch(input int n);
        {seenCore, seenIret, seenHost, seenOff, seenRet} = '0;
        repeat (n) begin
            @(posedge clk);
            seenCore = seenCore | coreIrq;
            seenIret = seenIret | coreIret;
            seenHost = seenHost | hostIrq;
            seenOff  = seenOff | driversDisable;
            seenRet  = seenRet | returnToExtRef;
        end
    endtask

    // Reset values, an unmapped word and the fixed response.
    task automatic t_reset();
        chk(32'(pllFactorHigh), 32'h1);
        chk(32'(pllSpreadOn), 32'h1);
        bus(1'b0, IDX_PLL_CFG, 32'h0);
        chk(rd, {16'h0, RST_PLL_CFG});
        bus(1'b0, IDX_BKP_CLK, 32'h0);
        chk(rd, {16'h0, RST_BKP_CLK});
        bus(1'b1, 9'h1ff, 32'hffff_ffff);
        bus(1'b0, 9'h1ff, 32'h0);
        chk(rd, 32'h0);
        chk(32'(hresp), 32'h0);
    endtask

    // The factor waits for a monitor tick; a command reset restores it.
    task automatic t_pll();
        @(posedge clk iff clockMonitorTick === 1'b1);
        bus(1'b1, IDX_PLL_CFG, 32'h0);
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            chk(32'(pllFactorHigh), 32'h1);
            if (clockMonitorTick === 1'b1) break;
        end
        repeat (2) @(posedge clk);
        chk(32'(pllFactorHigh), 32'h0);
        bus(1'b1, IDX_PLL_CFG, 32'h2);
        repeat (2) @(posedge clk);
        chk(32'(pllSpreadOn), 32'h0);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, IDX_PLL_CFG, 32'h0);
        chk(rd, {16'h0, RST_PLL_CFG});
    endtask

    // Supply and divider bits, then the strap across both reset kinds.
    task automatic t_strap();
        bus(1'b1, IDX_DRV_CFG2, 32'h0000_8002);
        repeat (2) @(posedge clk);
        chk(32'(vccpExtEnable), 32'h1);
        chk(32'(boostDivBy4), 32'h1);
        bus(1'b1, IDX_DRV_CFG2, 32'h0);
        bootstrapInit <= 1'b1;
        debugPinIn    <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(vccpExtEnable), 32'h1);
        chk(32'(boostDivBy4), 32'h0);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(1'b1, IDX_DRV_CFG2, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(vccpExtEnable), 32'h1);
        externalReset_n <= 1'b0;
        repeat (2) @(posedge clk);
        externalReset_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(vccpExtEnable), 32'h0);
        bootstrapInit <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(vccpExtEnable), 32'h1);
    endtask

    // Every row of the boost undervoltage routing table.
    task automatic t_boost();
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, IDX_DRV_CFG1, (32'(i[3]) << B1_BOOST_IE) |
                (i[1] ? (32'h3f << B1_CORE_RT) : 32'h0) |
                (32'(i[0]) << B1_HOST_RT));
            bus(1'b1, IDX_DRV_CFG2, 32'(i[2]) << B2_BOOST_DO);
            boostUvDetect <= 1'b1;
            watch(4);
            chk(32'(seenCore), (i[3] & i[2] & i[1]) ? 32'h3f : 32'h0);
            chk(32'(seenHost), 32'(i[3] & i[2] & i[0]));
            chk(32'(seenOff), 32'(i[2]));
            bus(1'b0, IDX_STATUS, 32'h0);
            chk(32'(rd[0]), 32'(i[2]));
            boostUvDetect <= 1'b0;
            watch(2);
            bus(1'b0, IDX_STATUS, 32'h0);
            watch(2);
        end
    endtask

    // Both return-request selections against both trigger events.
    task automatic t_iret();
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, IDX_DRV_CFG1, 32'(s) << B1_IRET_SEL);
            driversReenabled <= 1'b1;
            @(posedge clk);
            driversReenabled <= 1'b0;
            watch(3);
            chk(32'(seenIret), s ? 32'h0 : 32'h3f);
            driverStatusCleared <= 1'b1;
            @(posedge clk);
            driverStatusCleared <= 1'b0;
            watch(3);
            chk(32'(seenIret), s ? 32'h3f : 32'h0);
        end
    endtask

    // Clock loss, the held host interrupt and both kinds of return.
    task automatic t_clock();
        logic [31:0] cfg;
        cfg = (32'h1 << BB_CLK_DO) | (32'h15 << BB_CORE_IE) |
              (32'h1 << BB_HOST_IE);
        bus(1'b1, IDX_DRV_CFG1, 32'h0);
        bus(1'b1, IDX_BKP_CLK, cfg);
        loseClock <= 1'b1;
        watch(6);
        chk(32'(seenCore), 32'h15);
        chk(32'(seenOff), 32'h1);
        driversReenabled <= 1'b1;
        loseClock        <= 1'b0;
        @(posedge clk);
        driversReenabled <= 1'b0;
        watch(4);
        chk(32'(seenIret), 32'h0);
        chk(32'(driversDisable), 32'h0);
        chk(32'(hostIrq), 32'h1);
        bus(1'b0, IDX_BKP_CLK, 32'h0);
        chk(rd, cfg | 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(hostIrq), 32'h0);
        bus(1'b1, IDX_BKP_CLK, cfg | (32'h1 << BB_RETURN));
        watch(10);
        chk(32'(seenRet), 32'h1);
        chk(32'(seenCore), 32'h15);
        chk(32'(returnToExtRef), 32'h0);
        bus(1'b0, IDX_BKP_CLK, 32'h0);
        chk(rd, cfg);
        bus(1'b1, IDX_BKP_CLK, cfg | (32'h1 << BB_RETURN));
        watch(3);
        chk(32'(seenRet), 32'h0);
        chk(32'(seenCore), 32'h0);
        bus(1'b0, IDX_BKP_CLK, 32'h0);
        chk(rd, cfg);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Print the counts and the verdict, then stop.
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Six cycles of reset with the strap low, then every scenario.
    initial begin
        {reset, powerOnReset_n, externalReset_n, debugPinIn} = 4'b1000;
        {boostUvDetect, bootstrapInit, loseClock, hsel, hwrite} = 5'b0;
        {driversReenabled, driverStatusCleared, htrans} = 4'b0;
        {hsize, haddr, hwdata} = {3'b010, 64'h0};
        repeat (6) @(posedge clk);
        reset           <= 1'b0;
        powerOnReset_n  <= 1'b1;
        externalReset_n <= 1'b1;
        t_reset();
        t_pll();
        t_strap();
        t_boost();
        t_iret();
        t_clock();
        print_verdict();
    end

    // The full run needs under two thousand cycles; a hang stops here.
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule
